/* hw/pip_consts.vh */
`ifndef PIP_CONSTS_VH
`define PIP_CONSTS_VH
// register byte offsets on the plain register port
`define PIP_ADDR_W          8
`define PIP_OFS_HVI_CTRL    8'h00
`define PIP_OFS_HVI_DIG     8'h01
`define PIP_OFS_HVI_RATIO   8'h02
`define PIP_OFS_EXT_IRQ     8'h03
`define PIP_OFS_PORTP_IE    8'h04
`define PIP_OFS_PORTP_IF    8'h05
`define PIP_OFS_PORTP_POL   8'h06
`define PIP_OFS_PORTL_IE    8'h07
`define PIP_OFS_PORTL_IF    8'h08
`define PIP_OFS_PORTL_POL   8'h09
`define PIP_OFS_PORTAD_IE   8'h0A
`define PIP_OFS_PORTAD_IF   8'h0B
`define PIP_OFS_PORTAD_POL  8'h0C
`define PIP_OFS_MISC        8'h0D
`define PIP_OFS_PIN_STATE   8'h0E
// hvi analog control fields
`define PIP_HC_SEL_LO       0
`define PIP_HC_SEL_HI       1
`define PIP_HC_DIRECT       2
`define PIP_HC_BYPASS       3
`define PIP_HC_FORCE        4
`define PIP_HC_ENABLE       7
// ext irq control fields
`define PIP_EI_EDGE         6
`define PIP_EI_ENABLE       7
// port p bits
`define PIP_OC_BIT          7
`define PIP_SUPPLY_BIT      2
// misc control fields
`define PIP_MISC_OC_PWR     0
`define PIP_MISC_TRIG_REL   1
// widths and counts
`define PIP_NP              6
`define PIP_NL              4
`define PIP_NAD             6
`define PIP_NPINS           16
`define PIP_FILT_N          3'h4
`define PIP_RST_BYTE        8'h00
`endif

/* hw/pip_pin_filter.v */
`timescale 1ns/1ps
`include "pip_consts.vh"
// glitch filter: four passive samples then four active samples give one edge
module pip_pin_filter (
    input  wire       clk,
    input  wire       rst,
    input  wire       sample_en,
    input  wire       pin,
    input  wire       active_high,
    output wire       edge_seen,
    output wire       count_low
);
    reg       phase_r;   // 0 gathering passive samples, 1 gathering active ones
    reg [2:0] cnt_r;
    wire      act = (pin == active_high);

    // any break in the pattern restarts sampling
    always @(posedge clk) begin
        if (rst) begin
            phase_r <= 1'b0;
            cnt_r   <= 3'h0;
        end else if (sample_en) begin
            if (!phase_r) begin
                if (act) begin
                    if (cnt_r == `PIP_FILT_N) begin
                        phase_r <= 1'b1;
                        cnt_r   <= 3'h1;
                    end else begin
                        cnt_r <= 3'h0;
                    end
                end else if (cnt_r != `PIP_FILT_N) begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end else begin
                if (!act) begin
                    phase_r <= 1'b0;
                    cnt_r   <= 3'h1;
                end else if (cnt_r != `PIP_FILT_N) begin
                    cnt_r <= cnt_r + 3'h1;
                end else begin
                    phase_r <= 1'b0;  // edge taken, wait for passive again
                    cnt_r   <= 3'h0;
                end
            end
        end
    end

    assign edge_seen = sample_en && phase_r && act && (cnt_r == `PIP_FILT_N - 3'h1);
    assign count_low = (cnt_r <= `PIP_FILT_N);
endmodule

/* hw/pip_port_integration.v */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pip_consts.vh"
// What this block does
// - analog enable routes selected input to adc
// - per-pin divider ratio, or direct input bypass
// - direct mode: converter bypass bit steers path
// - run mode: analog pin buffer off, no irq
// - force bit reenables buffer unless direct input
// - stop: analog off, buffer follows digital enable
// - run: digital enable alone gives digital input
// - nonmaskable pin requests only after x cleared
// - maskable pin: enable and i clear, level/edge
// - clearing enable withdraws pending maskable request
// - both ext pins wake stop, unfiltered
// - three ports, per-pin enable, edge polarity
// - flag and enable raise irq and wake
// - four passive then four active samples
// - filters on bus clock, rc clock in stop
// - rc runs in stop while any pin enabled, unflagged
// - overcurrent sets flag, irq when enabled
// - flag holds supply pin low until cleared
// - adc triggers follow pwm 5-4 relocation
// - enabled external pwm drives trigger, else pin function
// - monitor needs power-up bit, off in stop
module pip_port_integration (
    input  wire                   clk,
    input  wire                   rst,
    input  wire [`PIP_ADDR_W-1:0] addr,
    input  wire [7:0]             wdata,
    input  wire                   wr,
    input  wire                   rd,
    output reg  [7:0]             rdata,
    input  wire                   stop_mode,
    input  wire                   rc_tick,
    input  wire                   cpu_x_mask,
    input  wire                   cpu_i_mask,
    input  wire                   nonmaskable_irq_pin_n,
    input  wire                   ext_irq_pin_n,
    input  wire [`PIP_NP-1:0]     portp_pin,
    input  wire [`PIP_NL-1:0]     portl_pin,
    input  wire [`PIP_NAD-1:0]    portad_pin,
    input  wire                   overcurrent_detect,
    input  wire                   supply_pin_output_value,
    input  wire [1:0]             pwm_enable,
    input  wire [1:0]             pwm_internal,
    input  wire [1:0]             pwm_out,
    input  wire [1:0]             trig_pin_main,
    input  wire [1:0]             trig_pin_alt,
    output wire                   hvi_analog_on,
    output wire [1:0]             hvi_pin_select,
    output wire                   hvi_ratio_high,
    output wire                   hvi_direct_input,
    output wire                   hvi_converter_bypass,
    output wire [`PIP_NL-1:0]     hvi_buffer_enable,
    output wire                   nonmaskable_irq_req,
    output wire                   ext_irq_req,
    output wire                   portp_irq,
    output wire                   portl_irq,
    output wire                   portad_irq,
    output wire                   overcurrent_irq,
    output wire                   stop_wakeup,
    output wire                   rc_osc_run,
    output wire                   supply_output_pin,
    output wire                   overcurrent_monitor_on,
    output wire [1:0]             adc_external_trigger
);
    reg  [7:0]              hvi_analog_control_r;
    reg  [`PIP_NL-1:0]      hvi_digital_enable_r;
    reg  [`PIP_NL-1:0]      hvi_divider_ratio_select_r;
    reg  [7:0]              ext_irq_control_r;
    reg  [7:0]              portp_irq_enable_r;
    reg  [7:0]              portp_irq_flag_r;
    reg  [`PIP_NP-1:0]      portp_pol_r;
    reg  [`PIP_NL-1:0]      portl_irq_enable_r;
    reg  [`PIP_NL-1:0]      portl_irq_flag_r;
    reg  [`PIP_NL-1:0]      portl_pol_r;
    reg  [`PIP_NAD-1:0]     portad_irq_enable_r;
    reg  [`PIP_NAD-1:0]     portad_irq_flag_r;
    reg  [`PIP_NAD-1:0]     portad_pol_r;
    reg  [7:0]              port_misc_control_r;
    reg                     ext_pin_d_r;
    reg                     ext_edge_pend_r;
    reg  [7:0]              rdata_nxt;

    wire                    analog_en = hvi_analog_control_r[`PIP_HC_ENABLE];
    wire                    direct    = hvi_analog_control_r[`PIP_HC_DIRECT];
    wire [1:0]              sel       = hvi_analog_control_r[`PIP_HC_SEL_HI:`PIP_HC_SEL_LO];
    wire                    wr_hit_p  = wr && (addr == `PIP_OFS_PORTP_IF);
    wire                    wr_hit_l  = wr && (addr == `PIP_OFS_PORTL_IF);
    wire                    wr_hit_ad = wr && (addr == `PIP_OFS_PORTAD_IF);

    // analog path controls; in stop the analog input is always off
    assign hvi_analog_on        = analog_en && !stop_mode;
    assign hvi_pin_select       = sel;
    assign hvi_ratio_high       = hvi_divider_ratio_select_r[sel];
    assign hvi_direct_input     = direct;
    assign hvi_converter_bypass = direct && hvi_analog_control_r[`PIP_HC_BYPASS];

    // digital input buffer per hvi pin
    genvar g;
    generate
        for (g = 0; g < `PIP_NL; g = g + 1) begin : hbuf
            wire is_sel = analog_en && (sel == g);
            wire forced = hvi_analog_control_r[`PIP_HC_FORCE] && !direct;
            assign hvi_buffer_enable[g] = stop_mode ? hvi_digital_enable_r[g] :
                (is_sel ? forced : hvi_digital_enable_r[g]);
        end
    endgenerate

    // filters share one sampling enable: every bus clock in run/wait, rc ticks in stop
    wire                    samp_en = stop_mode ? rc_tick : 1'b1;
    wire [`PIP_NPINS-1:0]   pins    = {portad_pin, portl_pin & hvi_buffer_enable, portp_pin};
    wire [`PIP_NPINS-1:0]   pol     = {portad_pol_r, portl_pol_r, portp_pol_r};
    wire [`PIP_NPINS-1:0]   edges;
    wire [`PIP_NPINS-1:0]   cnt_low;
    generate
        for (g = 0; g < `PIP_NPINS; g = g + 1) begin : filt
            pip_pin_filter u_filt (
                .clk         (clk),
                .rst         (rst),
                .sample_en   (samp_en),
                .pin         (pins[g]),
                .active_high (pol[g]),
                .edge_seen   (edges[g]),
                .count_low   (cnt_low[g])
            );
        end
    endgenerate

    wire [`PIP_NP-1:0]  ev_p  = edges[`PIP_NP-1:0];
    wire [`PIP_NL-1:0]  ev_l  = edges[`PIP_NP+`PIP_NL-1:`PIP_NP] & hvi_buffer_enable;
    wire [`PIP_NAD-1:0] ev_ad = edges[`PIP_NPINS-1:`PIP_NP+`PIP_NL];
    wire [`PIP_NPINS-1:0] en_all = {portad_irq_enable_r, portl_irq_enable_r,
                                    portp_irq_enable_r[`PIP_NP-1:0]};
    wire [`PIP_NPINS-1:0] fl_all = {portad_irq_flag_r, portl_irq_flag_r,
                                    portp_irq_flag_r[`PIP_NP-1:0]};
    assign rc_osc_run = stop_mode && |(cnt_low & en_all & ~fl_all);

    // overcurrent monitor only in run mode with power-up bit, only while driven high
    assign overcurrent_monitor_on = port_misc_control_r[`PIP_MISC_OC_PWR] && !stop_mode;
    wire oc_event = overcurrent_monitor_on && supply_pin_output_value
                    && overcurrent_detect;
    wire oc_flag  = portp_irq_flag_r[`PIP_OC_BIT];
    assign supply_output_pin = supply_pin_output_value && !oc_flag;

    // pin irq per port, one vector each
    assign portp_irq  = |(portp_irq_flag_r[`PIP_NP-1:0] & portp_irq_enable_r[`PIP_NP-1:0]);
    assign portl_irq  = |(portl_irq_flag_r & portl_irq_enable_r);
    assign portad_irq = |(portad_irq_flag_r & portad_irq_enable_r);
    assign overcurrent_irq = oc_flag && portp_irq_enable_r[`PIP_OC_BIT];

    // external pins: nonmaskable gated only by the cpu x bit, maskable by enable and i bit
    assign nonmaskable_irq_req = !nonmaskable_irq_pin_n && !cpu_x_mask;
    wire ext_enable = ext_irq_control_r[`PIP_EI_ENABLE];
    wire ext_active = ext_irq_control_r[`PIP_EI_EDGE] ? ext_edge_pend_r : !ext_irq_pin_n;
    assign ext_irq_req = ext_enable && ext_active && !cpu_i_mask;
    // no filter on these, so a stop wakeup is immediate
    assign stop_wakeup = stop_mode && ((!nonmaskable_irq_pin_n && !cpu_x_mask)
                         || (ext_enable && !ext_irq_pin_n)
                         || portp_irq || portl_irq || portad_irq);

    // adc triggers follow pwm 5-4 to main or relocated pin
    wire [1:0] trig_pin = port_misc_control_r[`PIP_MISC_TRIG_REL] ? trig_pin_alt
                                                                     : trig_pin_main;
    assign adc_external_trigger = (pwm_enable & ~pwm_internal & pwm_out)
                                | (~(pwm_enable & ~pwm_internal) & trig_pin);

    // falling edge latch for the maskable pin; disabling withdraws it
    always @(posedge clk) begin
        if (rst) begin
            ext_pin_d_r     <= 1'b1;
            ext_edge_pend_r <= 1'b0;
        end else begin
            ext_pin_d_r <= ext_irq_pin_n;
            if (ext_pin_d_r && !ext_irq_pin_n && ext_enable)
                ext_edge_pend_r <= 1'b1;
            else if (!ext_enable || !cpu_i_mask)
                ext_edge_pend_r <= 1'b0;  // taken when cpu unmasked
        end
    end

    // register writes; hardware set wins over write-one-to-clear
    always @(posedge clk) begin
        if (rst) begin
            hvi_analog_control_r       <= `PIP_RST_BYTE;
            hvi_digital_enable_r       <= {`PIP_NL{1'b0}};
            hvi_divider_ratio_select_r <= {`PIP_NL{1'b0}};
            ext_irq_control_r          <= `PIP_RST_BYTE;
            portp_irq_enable_r         <= `PIP_RST_BYTE;
            portp_irq_flag_r           <= `PIP_RST_BYTE;
            portp_pol_r                <= {`PIP_NP{1'b0}};
            portl_irq_enable_r         <= {`PIP_NL{1'b0}};
            portl_irq_flag_r           <= {`PIP_NL{1'b0}};
            portl_pol_r                <= {`PIP_NL{1'b0}};
            portad_irq_enable_r        <= {`PIP_NAD{1'b0}};
            portad_irq_flag_r          <= {`PIP_NAD{1'b0}};
            portad_pol_r               <= {`PIP_NAD{1'b0}};
            port_misc_control_r        <= `PIP_RST_BYTE;
        end else begin
            if (wr) begin
                case (addr)
                    `PIP_OFS_HVI_CTRL:   hvi_analog_control_r <= wdata;
                    `PIP_OFS_HVI_DIG:    hvi_digital_enable_r <= wdata[`PIP_NL-1:0];
                    `PIP_OFS_HVI_RATIO:  hvi_divider_ratio_select_r <= wdata[`PIP_NL-1:0];
                    `PIP_OFS_EXT_IRQ:    ext_irq_control_r <= wdata;
                    `PIP_OFS_PORTP_IE:   portp_irq_enable_r <= wdata;
                    `PIP_OFS_PORTP_POL:  portp_pol_r <= wdata[`PIP_NP-1:0];
                    `PIP_OFS_PORTL_IE:   portl_irq_enable_r <= wdata[`PIP_NL-1:0];
                    `PIP_OFS_PORTL_POL:  portl_pol_r <= wdata[`PIP_NL-1:0];
                    `PIP_OFS_PORTAD_IE:  portad_irq_enable_r <= wdata[`PIP_NAD-1:0];
                    `PIP_OFS_PORTAD_POL: portad_pol_r <= wdata[`PIP_NAD-1:0];
                    `PIP_OFS_MISC:       port_misc_control_r <= wdata;
                    default: ;
                endcase
            end
            // flags: edges latch regardless of enable, so usable for outputs too
            portp_irq_flag_r <= (portp_irq_flag_r & ~(wr_hit_p ? wdata : `PIP_RST_BYTE))
                              | {oc_event, 1'b0, ev_p};
            portl_irq_flag_r <= (portl_irq_flag_r & ~(wr_hit_l ? wdata[`PIP_NL-1:0]
                                : {`PIP_NL{1'b0}})) | ev_l;
            portad_irq_flag_r <= (portad_irq_flag_r & ~(wr_hit_ad ? wdata[`PIP_NAD-1:0]
                                 : {`PIP_NAD{1'b0}})) | ev_ad;
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_nxt = `PIP_RST_BYTE;
        case (addr)
            `PIP_OFS_HVI_CTRL:   rdata_nxt = hvi_analog_control_r;
            `PIP_OFS_HVI_DIG:    rdata_nxt = {4'h0, hvi_digital_enable_r};
            `PIP_OFS_HVI_RATIO:  rdata_nxt = {4'h0, hvi_divider_ratio_select_r};
            `PIP_OFS_EXT_IRQ:    rdata_nxt = ext_irq_control_r;
            `PIP_OFS_PORTP_IE:   rdata_nxt = portp_irq_enable_r;
            `PIP_OFS_PORTP_IF:   rdata_nxt = portp_irq_flag_r;
            `PIP_OFS_PORTP_POL:  rdata_nxt = {2'h0, portp_pol_r};
            `PIP_OFS_PORTL_IE:   rdata_nxt = {4'h0, portl_irq_enable_r};
            `PIP_OFS_PORTL_IF:   rdata_nxt = {4'h0, portl_irq_flag_r};
            `PIP_OFS_PORTL_POL:  rdata_nxt = {4'h0, portl_pol_r};
            `PIP_OFS_PORTAD_IE:  rdata_nxt = {2'h0, portad_irq_enable_r};
            `PIP_OFS_PORTAD_IF:  rdata_nxt = {2'h0, portad_irq_flag_r};
            `PIP_OFS_PORTAD_POL: rdata_nxt = {2'h0, portad_pol_r};
            `PIP_OFS_MISC:       rdata_nxt = port_misc_control_r;
            `PIP_OFS_PIN_STATE:  rdata_nxt = {4'h0, portl_pin & hvi_buffer_enable};
            default:             rdata_nxt = `PIP_RST_BYTE;
        endcase
    end

    // read data stand one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (rst)
            rdata <= `PIP_RST_BYTE;
        else
            rdata <= rd ? rdata_nxt : `PIP_RST_BYTE;
    end
endmodule

/* verification/ppihc_monitor.sv */
`timescale 1ns/1ps
`include "pip_consts.vh"
// watches the port block from its own ports only
module ppihc_monitor (
    input wire                clk,
    input wire                rst,
    input wire                wr,
    input wire                stop_mode,
    input wire                cpu_x_mask,
    input wire                cpu_i_mask,
    input wire [`PIP_NAD-1:0] portad_pin,
    input wire [1:0]          pwm_enable,
    input wire [1:0]          pwm_internal,
    input wire [1:0]          pwm_out,
    input wire [1:0]          adc_external_trigger,
    input wire                supply_output_pin,
    input wire                overcurrent_monitor_on,
    input wire                hvi_analog_on,
    input wire                nonmaskable_irq_req,
    input wire                ext_irq_req,
    input wire                portp_irq,
    input wire                portl_irq,
    input wire                portad_irq,
    input wire                overcurrent_irq,
    input wire                stop_wakeup
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // no request but the nonmaskable one may come in the first cycle out of reset
    quiet_reset_a: assert property ($past(rst) |-> !ext_irq_req && !portp_irq && !portl_irq
        && !portad_irq && !overcurrent_irq) else $error("request right after reset");
    nmi_mask_a: assert property (cpu_x_mask |-> !nonmaskable_irq_req)
        else $error("nonmaskable request while masked");
    ext_mask_a: assert property (cpu_i_mask |-> !ext_irq_req)
        else $error("maskable request while masked");
    oc_pin_low_a: assert property (overcurrent_irq |-> !supply_output_pin)
        else $error("supply pin driven while flagged");
    monitor_stop_a: assert property (stop_mode |-> !overcurrent_monitor_on)
        else $error("current monitor on in stop");
    analog_stop_a: assert property (stop_mode |-> !hvi_analog_on)
        else $error("analog path on in stop");
    // an enabled, external pwm channel owns its trigger
    trig_pwm_a: assert property (((pwm_enable & ~pwm_internal)
        & (adc_external_trigger ^ pwm_out)) == 2'b00) else $error("trigger not from pwm");
    // a flag raised by the filter needs equal pin samples one and four cycles before it
    filter_min_a: assert property ($rose(portad_irq) && !$past(wr) && !stop_mode
        |-> $past(portad_pin, 1) == $past(portad_pin, 4)) else $error("edge accepted too soon");
    wake_stop_a: assert property (stop_mode && (portp_irq || portl_irq || portad_irq)
        |-> stop_wakeup) else $error("no wakeup from pin request");

    cover property (overcurrent_irq);
    cover property ($rose(portl_irq));
    cover property (ext_irq_req);
endmodule

/* verification/ppihc_pin_model.sv */
`timescale 1ns/1ps
`include "pip_consts.vh"
// pins, load sensor and pwm sources around the port block; bench sets the regs
module ppihc_pin_model (
    input  wire                supply_output_pin,
    output wire                nonmaskable_irq_pin_n,
    output wire                ext_irq_pin_n,
    output wire [`PIP_NP-1:0]  portp_pin,
    output wire [`PIP_NL-1:0]  portl_pin,
    output wire [`PIP_NAD-1:0] portad_pin,
    output wire                overcurrent_detect,
    output wire [1:0]          pwm_enable,
    output wire [1:0]          pwm_internal,
    output wire [1:0]          pwm_out,
    output wire [1:0]          trig_pin_main,
    output wire [1:0]          trig_pin_alt
);
    reg [15:0] pins_r  = 16'h0000;
    reg [1:0]  ext_n_r = 2'h3;
    reg        short_r = 1'b0;
    reg [5:0]  pwm_r   = 6'h00;
    reg [3:0]  trig_r  = 4'h0;

    // interrupt pins idle high through their pullups
    assign {ext_irq_pin_n, nonmaskable_irq_pin_n} = ext_n_r;
    assign {portad_pin, portl_pin, portp_pin} = pins_r;
    // a short only draws current while the pin is driven high
    assign overcurrent_detect = short_r & supply_output_pin;
    assign {pwm_enable, pwm_internal, pwm_out} = pwm_r;
    assign {trig_pin_alt, trig_pin_main} = trig_r;
endmodule

/* verification/port_pin_interrupt_hvi_control_tb_top.sv */
`timescale 1ns/1ps
`include "pip_consts.vh"
module port_pin_interrupt_hvi_control_tb_top;
    reg                    clk = 1'b0;
    reg                    rst = 1'b1;
    reg  [`PIP_ADDR_W-1:0] addr = 8'h00;
    reg  [7:0]             wdata = 8'h00;
    reg                    wr = 1'b0, rd = 1'b0, stop_mode = 1'b0, rc_tick = 1'b0;
    reg                    cpu_x_mask = 1'b1, cpu_i_mask = 1'b1, supply_pin_output_value = 1'b0;
    wire [7:0]             rdata;
    wire [`PIP_NP-1:0]     portp_pin;
    wire [`PIP_NL-1:0]     portl_pin, hvi_buffer_enable;
    wire [`PIP_NAD-1:0]    portad_pin;
    wire [1:0]             pwm_enable, pwm_internal, pwm_out, trig_pin_main, trig_pin_alt;
    wire [1:0]             hvi_pin_select, adc_external_trigger;
    wire                   nonmaskable_irq_pin_n, ext_irq_pin_n, overcurrent_detect;
    wire                   hvi_analog_on, hvi_ratio_high, hvi_direct_input, hvi_converter_bypass;
    wire                   nonmaskable_irq_req, ext_irq_req, portp_irq, portl_irq, portad_irq;
    wire                   overcurrent_irq, stop_wakeup, rc_osc_run, supply_output_pin;
    wire                   overcurrent_monitor_on;
    integer                errors = 0, num_checks = 0, k, p;
    // outputs bundled so one compare covers several of them
    wire [7:0] ev_v = {nonmaskable_irq_req, ext_irq_req, portp_irq, portl_irq, portad_irq,
                       overcurrent_irq, 1'b0, supply_output_pin};
    wire [7:0] hv_v = {hvi_analog_on, hvi_pin_select, hvi_ratio_high, hvi_direct_input,
                       hvi_converter_bypass, overcurrent_monitor_on, 1'b0};

    pip_port_integration dut (.*);
    ppihc_pin_model far (.*);

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) rc_tick <= ~rc_tick;

    task chk(input [7:0] got, input [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // single byte writes only, data never paired with direction
    task wr_reg(input [7:0] a, input [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task t_reset;
        for (k = 0; k < 14; k = k + 1)
            rd_chk(k[7:0], `PIP_RST_BYTE);
        wr_reg(8'h3F, 8'hFF);
        rd_chk(8'h3F, 8'h00);
        chk(ev_v, 8'h00);
        chk({4'h0, hvi_buffer_enable}, 8'h00);
        $display("test reset done");
    endtask
    task t_hvi;
        far.pins_r <= 16'h03C0;
        wr_reg(`PIP_OFS_HVI_DIG, 8'h0F);
        wr_reg(`PIP_OFS_HVI_RATIO, 8'h04);
        wr_reg(`PIP_OFS_HVI_CTRL, 8'h82);
        cyc(1);
        chk(hv_v, 8'hD0);
        chk({4'h0, hvi_buffer_enable}, 8'h0B);
        wr_reg(`PIP_OFS_HVI_CTRL, 8'h92);
        cyc(1);
        chk({4'h0, hvi_buffer_enable}, 8'h0F);
        wr_reg(`PIP_OFS_HVI_CTRL, 8'h9E);
        cyc(1);
        chk(hv_v, 8'hDC);
        chk({4'h0, hvi_buffer_enable}, 8'h0B);
        stop_mode <= 1'b1;
        wr_reg(`PIP_OFS_HVI_DIG, 8'h05);
        cyc(1);
        chk({4'h0, hvi_buffer_enable}, 8'h05);
        stop_mode <= 1'b0;
        wr_reg(`PIP_OFS_HVI_CTRL, 8'h00);
        cyc(1);
        chk({4'h0, hvi_buffer_enable}, 8'h05);
        rd_chk(`PIP_OFS_PIN_STATE, 8'h05);
        rd_chk(`PIP_OFS_PORTL_IF, 8'h00);
        $display("test hvi done");
    endtask
    // bit 0 of each port, both polarities: glitch, edge, flag clear
    task t_pins;
        reg [15:0] idle;
        reg [15:0] hit;
        reg [7:0]  base;
        for (k = 0; k < 3; k = k + 1) begin
            for (p = 0; p < 2; p = p + 1) begin
                base = 8'h04 + 8'(3 * k);
                idle = p ? 16'h0000 : 16'hFFFF;
                hit = idle ^ ((k == 0) ? 16'h0001 : (k == 1) ? 16'h0040 : 16'h0400);
                far.pins_r <= idle;
                wr_reg(base + 8'h02, p[7:0]);
                cyc(6);
                wr_reg(base + 8'h01, 8'h7F);
                wr_reg(base, 8'h01);
                far.pins_r <= hit;
                cyc(3);
                far.pins_r <= idle;
                cyc(6);
                chk(ev_v, 8'h00);
                far.pins_r <= hit;
                cyc(6);
                chk(ev_v, 8'h20 >> k);
                rd_chk(base + 8'h01, 8'h01);
                stop_mode <= 1'b1;
                wr_reg(base + 8'h01, 8'h00);
                cyc(1);
                chk({6'h00, rc_osc_run, stop_wakeup}, 8'h01);
                wr_reg(base + 8'h01, 8'h01);
                cyc(1);
                chk({6'h00, rc_osc_run, stop_wakeup}, 8'h02);
                stop_mode <= 1'b0;
                chk(ev_v, 8'h00);
                wr_reg(base, 8'h00);
            end
        end
        $display("test pins done");
    endtask
    task t_ext;
        far.ext_n_r <= 2'b10;
        cyc(2);
        chk(ev_v, 8'h00);
        cpu_x_mask <= 1'b0;
        cyc(1);
        chk(ev_v, 8'h80);
        far.ext_n_r <= 2'b01;
        cpu_i_mask <= 1'b0;
        cyc(2);
        chk(ev_v, 8'h00);
        wr_reg(`PIP_OFS_EXT_IRQ, 8'h80);
        cyc(1);
        chk(ev_v, 8'h40);
        stop_mode <= 1'b1;
        cyc(1);
        chk({7'h00, stop_wakeup}, 8'h01);
        stop_mode <= 1'b0;
        wr_reg(`PIP_OFS_EXT_IRQ, 8'h00);
        cyc(1);
        chk(ev_v, 8'h00);
        // falling edge latched while masked shows once unmasked
        far.ext_n_r <= 2'b11;
        cpu_i_mask <= 1'b1;
        wr_reg(`PIP_OFS_EXT_IRQ, 8'hC0);
        far.ext_n_r <= 2'b01;
        cyc(2);
        cpu_i_mask <= 1'b0;
        #1 chk(ev_v, 8'h40);
        // masked again, the pending edge must not survive a disable
        cpu_i_mask <= 1'b1;
        wr_reg(`PIP_OFS_EXT_IRQ, 8'h40);
        wr_reg(`PIP_OFS_EXT_IRQ, 8'hC0);
        cpu_i_mask <= 1'b0;
        cyc(1);
        chk(ev_v, 8'h00);
        far.ext_n_r <= 2'b11;
        cpu_x_mask <= 1'b1;
        $display("test ext done");
    endtask
    task t_oc;
        wr_reg(`PIP_OFS_PORTP_IF, 8'h7F);
        supply_pin_output_value <= 1'b1;
        far.short_r <= 1'b1;
        cyc(3);
        chk(ev_v, 8'h01);
        supply_pin_output_value <= 1'b0;
        wr_reg(`PIP_OFS_MISC, 8'h01);
        wr_reg(`PIP_OFS_PORTP_IE, 8'h80);
        cyc(3);
        chk(ev_v, 8'h00);
        supply_pin_output_value <= 1'b1;
        cyc(3);
        chk(ev_v, 8'h04);
        rd_chk(`PIP_OFS_PORTP_IF, 8'h80);
        far.short_r <= 1'b0;
        cyc(3);
        chk(ev_v, 8'h04);
        wr_reg(`PIP_OFS_PORTP_IF, 8'h80);
        cyc(1);
        chk(ev_v, 8'h01);
        stop_mode <= 1'b1;
        cyc(1);
        chk({7'h00, overcurrent_monitor_on}, 8'h00);
        stop_mode <= 1'b0;
        supply_pin_output_value <= 1'b0;
        $display("test overcurrent done");
    endtask
    task t_trig;
        far.trig_r <= 4'h9;
        wr_reg(`PIP_OFS_MISC, 8'h00);
        cyc(1);
        chk({6'h00, adc_external_trigger}, 8'h01);
        wr_reg(`PIP_OFS_MISC, 8'h02);
        cyc(1);
        chk({6'h00, adc_external_trigger}, 8'h02);
        far.pwm_r <= 6'h31;
        cyc(1);
        chk({6'h00, adc_external_trigger}, 8'h01);
        far.pwm_r <= 6'h35;
        cyc(1);
        chk({6'h00, adc_external_trigger}, 8'h00);
        $display("test trigger done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_hvi;
        t_pins;
        t_ext;
        t_oc;
        t_trig;
        report_and_stop;
    end
    // the whole run needs well under a tenth of this
    initial begin
        #200000;
        errors = errors + 1;
        report_and_stop;
    end
endmodule

bind pip_port_integration ppihc_monitor mon (.*);
